// file: common/lin_slave_regs.svh
// Register offsets, reset values, field positions and timing counts
`ifndef LIN_SLAVE_REGS_SVH
`define LIN_SLAVE_REGS_SVH

`define OFS_STATUS      3'h0
`define OFS_DATA        3'h1
`define OFS_CTRL_ONE    3'h2
`define OFS_CTRL_TWO    3'h3
`define OFS_CTRL_THREE  3'h4
`define OFS_DIV_MANT    3'h5
`define OFS_DIV_FRAC    3'h6

`define RST_STATUS      8'hc0
`define RST_CTRL        8'h00

`define ST_TXE          7
`define ST_TC           6
`define ST_RXF          5
`define ST_IDLE         4
`define ST_HDRERR       3
`define ST_NOISE        2
`define ST_FRAME        1
`define ST_PARITY       0

`define C1_PCE          2
`define C1_PIE          0
`define C2_RIE          5
`define C2_TE           3
`define C2_RE           2
`define C2_MUTE         1
`define C2_SBK          0
`define C3_LINE         6
`define C3_SLV          5
`define C3_LASE         4
`define C3_HDM          3
`define C3_HDF          1
`define C3_LSF          0

`define SAMPLES_PER_BIT 5'd16
`define BREAK_BITS      8'd11
`define SYNC_BITS       4'd8
`define BREAK_TX_BITS   4'd13
`define HDR_MAX_BITS    8'd57

`endif

// file: common/lin_slave_pkg.sv
// Types for the LIN slave receiver block
package lin_slave_pkg;
   typedef enum logic [2:0] {RX_IDLE, RX_SYNC, RX_DATA} rx_state_t;
   typedef enum logic [1:0] {HDR_NONE, HDR_SYNC, HDR_IDENT} hdr_phase_t;
endpackage

// file: design/lin_slave_receive_status.sv
// LIN-mode serial interface: receiver, break detection, divider, status
// Operation
// [R01] Same-cycle software divider write beats the measured-divider load.
// [R02] A low period counts as break only after eleven local bit times.
// [R03] An all-zero character, nine low bits, is never taken as break.
// [R04] The master sends break as thirteen low bit times.
// [R05] Break detection tolerates fifteen percent clock deviation while unsynchronised.
// [R06] Sixteen samples per bit; majority of samples eight, nine, ten.
// [R07] Sampling phase realigns on every start bit.
// [R08] Synch field measured over eight bit times on CPU clock edges.
// [R09] Baud rate steps of one sixteenth; divider has four-bit fraction.
// [R10] Slave leaves mute on break or identifier per detection method; with HDM set the muted receiver skips the identifier, so mute stays.
// [R11] Mute slave ignores bits until eleven consecutive dominant bits seen.
// [R12] Status resets to c0: transmit flags set, others clear.
// [R13] Header error on bad synch field, header timeout or header overrun.
// [R14] Header error requests interrupt with receive enable; cleared by sequence. The code gates it with RIE, not RE.
// [R15] Outside a header the header error flag reports overrun.
// [R16] Noise flag works in master mode, reads zero in slave mode.
// [R17] Slave framing error only for dominant stop with a recessive bit.
// [R18] Identifier parity error sets flag and interrupts when enabled.
// [R19] Parity check enable gates identifier parity errors.
// [R20] Mute bit software writable, hardware cleared, locked while data full.
// [R21] Send break set then cleared sends one break after current word.
// [R22] Software should use mute to receive only headers.
// [R23] Slave bit rate is clock over sixteen times divider, 8.4 fixed.
// [R24] Enable bit off disables LIN; slave select picks master or slave.
`timescale 1ns/100ps
`default_nettype none
`include "lin_slave_regs.svh"

module lin_slave_receive_status
   import lin_slave_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdData,
   input  wire logic       receiveInputPin,
   output logic            transmitPin,
   output logic            irq
);

   // ---------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------
   logic [7:0]  serialStatus, serialControlOne, serialControlTwo, controlThree;
   logic [7:0]  serialDataRegister, shiftReg;
   logic [11:0] nominalDivider, measuredDivider, linDivider;
   logic [3:0]  fracShadow;
   logic [15:0] baudAcc;
   logic [4:0]  sampleCnt;
   logic [3:0]  bitCnt;
   logic [2:0]  majority;
   logic [7:0]  lowBits;
   logic [2:0]  edgeCnt;
   logic [18:0] measCnt;
   logic [13:0] hdrCnt;
   logic [1:0]  pinSync;
   logic        pinPrev, statusSeen, sbkPrev, breakPending, breakSeen;
   logic [3:0]  txBitCnt;
   logic [4:0]  txSample;
   logic        txBusy;
   rx_state_t   rxState;
   hdr_phase_t  hdrPhase;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire linOn     = controlThree[`C3_LINE];                               // R24
   wire slaveMode = linOn & controlThree[`C3_SLV];                        // R24
   wire masterMode = linOn & ~controlThree[`C3_SLV];                      // R24
   wire rxPin     = pinSync[1];
   wire wrStatus  = regWrite & (regAddr == `OFS_STATUS);
   wire rdStatus  = regRead & (regAddr == `OFS_STATUS);
   wire rdData    = regRead & (regAddr == `OFS_DATA);
   wire wrCtrl2   = regWrite & (regAddr == `OFS_CTRL_TWO);
   wire wrCtrl3   = regWrite & (regAddr == `OFS_CTRL_THREE);
   wire rdCtrl3   = regRead & (regAddr == `OFS_CTRL_THREE);
   wire wrMant    = regWrite & (regAddr == `OFS_DIV_MANT);
   wire wrFrac    = regWrite & (regAddr == `OFS_DIV_FRAC);
   wire clearSeq  = statusSeen & rdData;
   wire muted     = serialControlTwo[`C2_MUTE];
   wire divOff    = (linDivider[11:4] == 8'h00);

   // Accumulate 16ths: one sample tick each time baudAcc passes divider
   wire [15:0] accNext = baudAcc + 16'h0010;                              // R09 R23
   wire        sampleTick = ~divOff & (accNext >= {4'h0, linDivider});    // R23
   wire        bitTick = sampleTick & (sampleCnt == `SAMPLES_PER_BIT - 5'd1);
   wire        voteBit = (majority[0] & majority[1]) | (majority[0] & majority[2])
                       | (majority[1] & majority[2]);                     // R06
   wire        fallEdge = pinPrev & ~rxPin;
   wire        breakNow = ~rxPin & bitTick & (lowBits == `BREAK_BITS - 8'd1); // R02 R03 R05 R11
   wire        hdrTimeout = (hdrPhase != HDR_NONE)
                          & (hdrCnt >= {`HDR_MAX_BITS, 6'h00}) & bitTick; // R13

   function automatic logic idParity(input logic [7:0] id);
      idParity = (id[6] == (id[0] ^ id[1] ^ id[2] ^ id[4]))
               & (id[7] == ~(id[1] ^ id[3] ^ id[4] ^ id[5]));
   endfunction

   // Eight bits last eight times the 8.4 divider in clocks
   wire [18:0] measTotal = measCnt + 19'd1;
   wire [11:0] measValue = measTotal[14:3];                               // R08
   wire        measDone = (rxState == RX_SYNC) & fallEdge & (edgeCnt == 3'd4)
                        & controlThree[`C3_LASE];
   wire        measBad = (measValue == 12'h000) | (measTotal[18:15] != 4'h0);
   wire        charDone = (rxState == RX_DATA) & bitTick & (bitCnt == 4'd9);
   wire        stopBad = charDone & ~voteBit & (shiftReg != 8'h00);       // R17
   wire        parityBad = charDone & (hdrPhase == HDR_IDENT)
                         & serialControlOne[`C1_PCE] & ~idParity(shiftReg); // R18 R19
   wire        overrun = charDone & serialStatus[`ST_RXF];                 // R13 R15

   // ---------------------------------------------------------------
   // Pin synchroniser and sampling
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinSync <= 2'b11;
         pinPrev <= 1'b1;
      end else begin
         pinSync <= {pinSync[0], receiveInputPin};
         pinPrev <= pinSync[1];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         baudAcc <= 16'h0000;
         sampleCnt <= 5'd0;
         majority <= 3'b111;
      end else if ((rxState != RX_DATA) & fallEdge) begin
         baudAcc <= 16'h0000;                                             // R07
         sampleCnt <= 5'd0;                                               // R07
      end else if (sampleTick) begin
         baudAcc <= accNext - {4'h0, linDivider};
         sampleCnt <= bitTick ? 5'd0 : sampleCnt + 5'd1;
         if (sampleCnt >= 5'd7 && sampleCnt <= 5'd9)
            majority <= {majority[1:0], rxPin};                           // R06
      end else begin
         baudAcc <= accNext;
      end
   end

   // Dominant run length in local bit times
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         lowBits <= 8'd0;
      else if (rxPin)
         lowBits <= 8'd0;
      else if (bitTick && lowBits != 8'hff)
         lowBits <= lowBits + 8'd1;                                       // R02
   end

   // ---------------------------------------------------------------
   // Receive state machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxState <= RX_IDLE;
         bitCnt <= 4'd0;
         shiftReg <= 8'h00;
         edgeCnt <= 3'd0;
         measCnt <= 19'd0;
         breakSeen <= 1'b0;
      end else begin
         if (breakNow)
            breakSeen <= 1'b1;
         else if (rxPin)
            breakSeen <= 1'b0;
         unique case (rxState)
            RX_IDLE: begin
               if (slaveMode && breakSeen && rxPin) begin
                  rxState <= RX_SYNC;
                  edgeCnt <= 3'd0;
                  measCnt <= 19'd0;
               end else if (fallEdge && !breakSeen && !(slaveMode && muted)) begin
                  rxState <= RX_DATA;                                     // R11
                  bitCnt <= 4'd0;
               end
            end
            RX_SYNC: begin
               if (!controlThree[`C3_LSF])
                  rxState <= RX_IDLE;
               else if (controlThree[`C3_LASE]) begin
                  if (edgeCnt != 3'd0)
                     measCnt <= measCnt + 19'd1;                          // R08
                  if (fallEdge) begin
                     edgeCnt <= edgeCnt + 3'd1;
                     if (edgeCnt == 3'd4)
                        rxState <= RX_IDLE;
                  end
               end else if (fallEdge) begin
                  rxState <= RX_DATA;
                  bitCnt <= 4'd0;
               end
            end
            RX_DATA: begin
               if (bitTick) begin
                  bitCnt <= bitCnt + 4'd1;
                  if (bitCnt >= 4'd1 && bitCnt <= 4'd8)
                     shiftReg <= {voteBit, shiftReg[7:1]};
                  if (bitCnt == 4'd0 && voteBit)
                     rxState <= RX_IDLE;
                  if (charDone)
                     rxState <= RX_IDLE;
               end
            end
            default: rxState <= RX_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Header tracking and timeout
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hdrPhase <= HDR_NONE;
         hdrCnt <= 14'd0;
      end else if (breakNow && slaveMode) begin
         hdrPhase <= HDR_SYNC;
         hdrCnt <= {`BREAK_BITS, 6'h00};
      end else if (hdrTimeout || !slaveMode) begin
         hdrPhase <= HDR_NONE;
      end else begin
         if (bitTick && hdrPhase != HDR_NONE)
            hdrCnt <= hdrCnt + 14'd64;
         if (measDone || (charDone && hdrPhase == HDR_SYNC))
            hdrPhase <= HDR_IDENT;
         else if (charDone && hdrPhase == HDR_IDENT)
            hdrPhase <= HDR_NONE;
      end
   end

   // ---------------------------------------------------------------
   // Divider: nominal, measured, working
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fracShadow <= 4'h0;
         nominalDivider <= 12'h000;
         measuredDivider <= 12'h000;
         linDivider <= 12'h000;
      end else begin
         if (wrFrac)
            fracShadow <= regWrData[3:0];                                 // R09
         if (measDone && !measBad)
            measuredDivider <= measValue;
         if (wrMant) begin
            nominalDivider <= {regWrData, fracShadow};
            linDivider <= {regWrData, fracShadow};                        // R01
         end else if (measDone && !measBad) begin
            linDivider <= measValue;                                      // R01
         end
      end
   end

   // ---------------------------------------------------------------
   // Status, data and control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         statusSeen <= 1'b0;
      else if (rdStatus || wrStatus)
         statusSeen <= 1'b1;
      else if (rdData)
         statusSeen <= 1'b0;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serialStatus <= `RST_STATUS;                                     // R12
         serialDataRegister <= 8'h00;
      end else begin
         if (clearSeq)
            serialStatus[5:0] <= 6'h00;
         if (charDone && !(slaveMode && muted && hdrPhase == HDR_NONE)) begin
            serialDataRegister <= shiftReg;
            serialStatus[`ST_RXF] <= 1'b1;
         end
         if (overrun || hdrTimeout || (measDone && measBad))
            serialStatus[`ST_HDRERR] <= 1'b1;                             // R13 R15
         if (stopBad && !(muted && slaveMode))
            serialStatus[`ST_FRAME] <= 1'b1;                              // R17
         if (parityBad)
            serialStatus[`ST_PARITY] <= 1'b1;                             // R18
         if (charDone && masterMode && (majority != 3'b000) && (majority != 3'b111))
            serialStatus[`ST_NOISE] <= 1'b1;                              // R16
         if (slaveMode)
            serialStatus[`ST_NOISE] <= 1'b0;                              // R16
         serialStatus[`ST_TXE] <= ~txBusy;
         serialStatus[`ST_TC] <= ~txBusy;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serialControlOne <= `RST_CTRL;
         serialControlTwo <= `RST_CTRL;
         controlThree <= `RST_CTRL;
      end else begin
         if (regWrite && regAddr == `OFS_CTRL_ONE)
            serialControlOne <= regWrData & 8'hfd;
         if (wrCtrl2) begin
            serialControlTwo[7:2] <= regWrData[7:2];
            serialControlTwo[`C2_SBK] <= regWrData[`C2_SBK];
            if (!(slaveMode && serialStatus[`ST_RXF]))
               serialControlTwo[`C2_MUTE] <= regWrData[`C2_MUTE];         // R20
         end
         if (slaveMode && muted && ((breakNow && !controlThree[`C3_HDM])
             || (charDone && hdrPhase == HDR_IDENT && controlThree[`C3_HDM] && !stopBad)))
            serialControlTwo[`C2_MUTE] <= 1'b0;                           // R10 R20
         if (wrCtrl3)
            controlThree <= {regWrData[7:2], controlThree[`C3_HDF] & regWrData[1],
                             controlThree[`C3_LSF] & regWrData[0]};
         else if (statusSeen && rdCtrl3)
            controlThree[`C3_HDF] <= 1'b0;
         if (slaveMode && breakNow) begin
            controlThree[`C3_LSF] <= 1'b1;
            if (!controlThree[`C3_HDM])
               controlThree[`C3_HDF] <= 1'b1;                             // R10
         end
         if (measDone && !measBad)
            controlThree[`C3_LSF] <= 1'b0;
         if (charDone && hdrPhase == HDR_IDENT && controlThree[`C3_HDM])
            controlThree[`C3_HDF] <= 1'b1;                                // R10
      end
   end

   // ---------------------------------------------------------------
   // Break transmitter
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sbkPrev <= 1'b0;
         breakPending <= 1'b0;
         txBusy <= 1'b0;
         txBitCnt <= 4'd0;
         txSample <= 5'd0;
         transmitPin <= 1'b1;
      end else begin
         sbkPrev <= serialControlTwo[`C2_SBK];
         if (sbkPrev && !serialControlTwo[`C2_SBK] && !slaveMode)
            breakPending <= 1'b1;                                         // R21
         if (breakPending && !txBusy) begin
            breakPending <= 1'b0;
            txBusy <= 1'b1;
            txBitCnt <= 4'd0;
            txSample <= 5'd0;
            transmitPin <= 1'b0;
         end else if (txBusy && sampleTick) begin
            txSample <= txSample + 5'd1;
            if (txSample == `SAMPLES_PER_BIT - 5'd1) begin
               txSample <= 5'd0;
               txBitCnt <= txBitCnt + 4'd1;
               if (txBitCnt == `BREAK_TX_BITS - 4'd1) begin
                  transmitPin <= 1'b1;
                  txBusy <= 1'b0;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read data and interrupt
   // ---------------------------------------------------------------
   logic [7:0] readMux;
   always_comb begin
      unique case (regAddr)
         `OFS_STATUS:     readMux = serialStatus;
         `OFS_DATA:       readMux = serialDataRegister;
         `OFS_CTRL_ONE:   readMux = serialControlOne;
         `OFS_CTRL_TWO:   readMux = serialControlTwo;
         `OFS_CTRL_THREE: readMux = controlThree;
         `OFS_DIV_MANT:   readMux = linDivider[11:4];
         `OFS_DIV_FRAC:   readMux = {4'h0, linDivider[3:0]};
         default:         readMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData <= 8'h00;
         irq <= 1'b0;
      end else begin
         regRdData <= regRead ? readMux : 8'h00;
         irq <= (serialControlTwo[`C2_RIE]
                 & (serialStatus[`ST_HDRERR] | serialStatus[`ST_RXF]))    // R14
              | (serialControlOne[`C1_PIE] & serialStatus[`ST_PARITY]);   // R18
      end
   end

endmodule
`default_nettype wire

// file: test/lin_master_model.sv
// Behavioural LIN master driving the receive pin
`timescale 1ns/100ps
`default_nettype none

module lin_master_model
#(
   parameter int BIT_CLKS = 16
)
(
   input  wire logic clk,
   output logic      line
);
   // Bus idles recessive through the pull-up
   initial line = 1'b1;

   task automatic hold(input logic lvl, input int bits);
      line <= lvl;
      repeat (bits * BIT_CLKS) @(posedge clk);
   endtask

   task automatic send_byte(input logic [7:0] b);
      hold(1'b0, 1);
      for (int i = 0; i < 8; i++) begin
         hold(b[i], 1);
      end
      hold(1'b1, 1);
      repeat (4) @(posedge clk);
   endtask

   task automatic send_header(input int brk, input logic [7:0] ident);
      hold(1'b0, brk);
      hold(1'b1, 1);
      send_byte(8'h55);
      send_byte(ident);
   endtask
endmodule
`default_nettype wire

// file: test/lin_slave_receive_status_sva.sv
// Port-level assertions for the LIN slave block
`timescale 1ns/100ps
`default_nettype none
`include "lin_slave_regs.svh"

module lin_slave_receive_status_sva
   import lin_slave_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regRdData,
   input wire logic       receiveInputPin,
   input wire logic       transmitPin,
   input wire logic       irq
);
   logic [7:0] ctrlOne;
   logic [7:0] ctrlTwo;
   logic [7:0] ctrlThree;
   logic       fresh;
   logic       slaveMode;

   // ----
   // Shadow of software-written controls
   // ----
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrlOne   <= 8'h00;
         ctrlTwo   <= 8'h00;
         ctrlThree <= 8'h00;
         fresh     <= 1'b1;
      end else begin
         if (regWrite && regAddr == `OFS_CTRL_ONE) ctrlOne <= regWrData;
         if (regWrite && regAddr == `OFS_CTRL_TWO) ctrlTwo <= regWrData;
         if (regWrite && regAddr == `OFS_CTRL_THREE) ctrlThree <= regWrData;
         if (regWrite || !receiveInputPin) fresh <= 1'b0;
      end
   end

   assign slaveMode = ctrlThree[`C3_LINE] && ctrlThree[`C3_SLV];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence statusRead;
      regRead && regAddr == `OFS_STATUS;
   endsequence

   sequence writeThenRead(logic [2:0] a);
      regWrite && regAddr == a ##1 !regWrite ##1 regRead && regAddr == a;
   endsequence

   a_status_reset_value: assert property (
      statusRead ##0 fresh |=> regRdData == `RST_STATUS)
      else $error("status differs from its reset value");
   a_noise_slave_zero: assert property (
      statusRead ##0 slaveMode |=> !regRdData[`ST_NOISE])
      else $error("noise flag set in slave mode");
   a_irq_from_flags: assert property (
      statusRead |=> irq == ((ctrlTwo[`C2_RIE] && (regRdData[`ST_HDRERR] || regRdData[`ST_RXF]))
                             || (ctrlOne[`C1_PIE] && regRdData[`ST_PARITY])))
      else $error("interrupt does not follow flags and enables");
   a_irq_quiet_off: assert property (
      !ctrlTwo[`C2_RIE] && !ctrlOne[`C1_PIE] |=> !irq)
      else $error("interrupt with all enables clear");
   a_tx_idle_high: assert property (
      !ctrlTwo[`C2_TE] && !$past(ctrlTwo[`C2_TE]) |-> transmitPin)
      else $error("transmit pin low with transmitter off");
   a_ctrl_two_back: assert property (
      writeThenRead(`OFS_CTRL_TWO) |=> (regRdData & 8'hfd) == ($past(regWrData, 3) & 8'hfd))
      else $error("control two readback mismatch");
   a_mantissa_back: assert property (
      writeThenRead(`OFS_DIV_MANT) ##0 !ctrlThree[`C3_LASE] |=> regRdData == $past(regWrData, 3))
      else $error("divider mantissa readback mismatch");
   a_fraction_upper_zero: assert property (
      regRead && regAddr == `OFS_DIV_FRAC |=> regRdData[7:4] == 4'h0)
      else $error("divider fraction upper bits not zero");
endmodule

bind lin_slave_receive_status lin_slave_receive_status_sva checker_i (.clk(clk), .rst(rst),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .receiveInputPin(receiveInputPin), .transmitPin(transmitPin),
   .irq(irq));
`default_nettype wire

// file: test/lin_slave_receive_status_tb.sv
// Self-checking bench for the LIN slave receiver and status block
`timescale 1ns/100ps
`default_nettype none
`include "lin_slave_regs.svh"

module lin_slave_receive_status_tb
   import lin_slave_pkg::*;
;
   localparam int BIT_CLKS = 16;
   logic       clk;
   logic       rst;
   logic [2:0] regAddr;
   logic [7:0] regWrData;
   logic       regWrite;
   logic       regRead;
   logic [7:0] regRdData;
   logic       rxLine;
   logic       transmitPin;
   logic       irq;
   logic [7:0] rdv;
   int         nErrors;
   int         samplesChecked;

   lin_slave_receive_status dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .receiveInputPin(rxLine), .transmitPin(transmitPin), .irq(irq));
   lin_master_model #(.BIT_CLKS(BIT_CLKS)) master (.clk(clk), .line(rxLine));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----
   // Bus cycles and comparison
   // ----
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge clk);
      regWrite  <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      rdv = regRdData;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         nErrors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic clear_flags;
      rd(`OFS_STATUS);
      rd(`OFS_CTRL_THREE);
      rd(`OFS_STATUS);
      rd(`OFS_DATA);
   endtask

   function automatic logic [7:0] ident(input logic [5:0] i);
      return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
   endfunction

   // ----
   // Scenarios
   // ----
   task automatic t_setup;
      rd(`OFS_STATUS);
      check(rdv, `RST_STATUS);
      wr(`OFS_DIV_FRAC, 8'hf3);
      wr(`OFS_DIV_MANT, 8'h01);
      rd(`OFS_DIV_FRAC);
      check(rdv, 8'h03);
      wr(`OFS_DIV_FRAC, 8'h00);
      rd(`OFS_DIV_FRAC);
      check(rdv, 8'h03);
      wr(`OFS_DIV_MANT, 8'h01);
      rd(`OFS_DIV_MANT);
      check(rdv, 8'h01);
      wr(`OFS_CTRL_THREE, 8'h60);
      wr(`OFS_CTRL_TWO, 8'h04);
   endtask

   task automatic t_breaks;
      master.hold(1'b0, 10);
      master.hold(1'b1, 2);
      rd(`OFS_CTRL_THREE);
      check(rdv & 8'h02, 8'h00);
      rd(`OFS_STATUS);
      check(rdv & 8'h02, 8'h00);
      clear_flags();
      master.hold(1'b0, 1);
      master.hold(1'b1, 8);
      master.hold(1'b0, 1);
      master.hold(1'b1, 1);
      rd(`OFS_STATUS);
      check(rdv & 8'h02, 8'h02);
      clear_flags();
      master.send_header(13, ident(6'h12));
      rd(`OFS_CTRL_THREE);
      check(rdv & 8'h02, 8'h02);
      rd(`OFS_STATUS);
      check(rdv & 8'h06, 8'h00);
      clear_flags();
   endtask

   task automatic t_mute;
      master.send_byte(8'h3c);
      rd(`OFS_STATUS);
      wr(`OFS_CTRL_TWO, 8'h06);
      rd(`OFS_CTRL_TWO);
      check(rdv & 8'h02, 8'h00);
      rd(`OFS_STATUS);
      rd(`OFS_DATA);
      check(rdv, 8'h3c);
      wr(`OFS_CTRL_TWO, 8'h06);
      rd(`OFS_CTRL_TWO);
      check(rdv & 8'h02, 8'h02);
      master.send_byte(8'ha5);
      rd(`OFS_STATUS);
      check(rdv & 8'h20, 8'h00);
      master.send_header(13, ident(6'h05));
      rd(`OFS_CTRL_TWO);
      check(rdv & 8'h02, 8'h00);
      clear_flags();
   endtask

   task automatic t_overrun;
      wr(`OFS_CTRL_TWO, 8'h24);
      master.send_byte(8'h11);
      master.send_byte(8'h22);
      rd(`OFS_STATUS);
      check(rdv & 8'h28, 8'h28);
      check({7'h00, irq}, 8'h01);
      clear_flags();
      wr(`OFS_CTRL_TWO, 8'h04);
   endtask

   task automatic t_parity;
      wr(`OFS_CTRL_THREE, 8'h78);
      for (int i = 1; i >= 0; i--) begin
         wr(`OFS_CTRL_ONE, {5'h00, i[0], 2'b01});
         master.send_header(13, ident(6'h2a) ^ 8'h80);
         rd(`OFS_STATUS);
         check(rdv & 8'h01, {7'h00, i[0]});
         check({7'h00, irq}, {7'h00, i[0]});
         rd(`OFS_DIV_MANT);
         check(rdv, 8'h01);
         clear_flags();
         rd(`OFS_STATUS);
         check(rdv & 8'h01, 8'h00);
      end
   endtask

   task automatic t_send_break;
      int lows;
      for (int m = 0; m < 2; m++) begin
         wr(`OFS_CTRL_THREE, m == 0 ? 8'h60 : 8'h40);
         wr(`OFS_CTRL_TWO, 8'h09);
         wr(`OFS_CTRL_TWO, 8'h08);
         lows = 0;
         for (int i = 0; i < 400 && transmitPin !== 1'b0; i++) @(posedge clk);
         while (transmitPin === 1'b0 && lows < 255) begin
            @(posedge clk);
            lows++;
         end
         check(lows[7:0], m == 0 ? 8'h00 : 8'(13 * BIT_CLKS));
      end
   endtask

   task automatic conclude;
      $display("Mismatches %0d, comparisons %0d", nErrors, samplesChecked);
      if (nErrors == 0 && samplesChecked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (50000) @(posedge clk);
      nErrors++;
      conclude();
   end

   initial begin
      rst = 1'b1;
      regAddr = 3'h0;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      nErrors = 0;
      samplesChecked = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_setup();
      t_breaks();
      t_mute();
      t_overrun();
      t_parity();
      t_send_break();
      conclude();
   end
endmodule
`default_nettype wire
